// *** core/ims_config_regs.sv ***
// Configuration register bank reached over the SPI slave port
`timescale 1ns/1ps
`include "ims_map.svh"
module ims_config_regs
   import ims_pkg::*;
#(
   parameter int unsigned TICK_CYCLES  = `IMS_TICK_CYCLES,
   parameter int unsigned READY_CYCLES = `IMS_READY_CYCLES,
   parameter int unsigned STAB_CYCLES  = `IMS_STAB_CYCLES
)
(
   input  wire logic           core_clk,
   input  wire logic           rst_n,
   input  wire logic           sclkPin,
   input  wire logic           mosiPin,
   input  wire logic           selectPin_n,
   input  wire logic           syncPin,
   input  wire ims_rate_raw_t  rateRaw,
   input  wire logic           alignDone,
   input  wire ims_align_res_t alignResult,
   output logic                miso,
   output logic                misoOe,
   output logic                dataReady,
   output logic                readyForUse,
   output logic                alignStart,
   output logic                nvmStore,
   output logic                stabilizeMode,
   output logic                useInternalClk,
   output logic [3:0]          outputRateSel,
   output logic [3:0]          rangeSel,
   output logic [7:0]          smoothingFilterSel,
   output ims_align_res_t      alignStore,
   output ims_rate_out_t       scaledRate
);
   ims_spi_word_t    rxWord;
   logic             rxValid;
   logic [15:0]      readBack;
   logic [15:0]      readData;
   logic [31:0]      readyCnt;
   logic             cmdValid;
   logic             cmdWrite;
   logic             diagRead;
   logic [6:0]       wordAddr;
   ims_rate_clk_t    rateClk;
   ims_range_filt_t  rangeFilt;
   logic [31:0]      msCnt;
   logic [1:0]       syncSync;
   logic             syncPrev;
   logic             msTick;
   logic [9:0]       ratePeriod;
   logic [9:0]       rateCnt;
   logic [1:0]       rangeShift;
   logic [19:0]      rangeLimit;
   logic [2:0]       exceed;
   logic             overRange;
   ims_align_state_t alignState;
   logic [7:0]       alignInit;
   logic [7:0]       alignStatus;
   logic             alignGo;
   logic [31:0]      stabCnt;

   ims_spi_shift u_spi
   (
      .core_clk    (core_clk),
      .rst_n       (rst_n),
      .sclkPin     (sclkPin),
      .mosiPin     (mosiPin),
      .selectPin_n (selectPin_n),
      .txWord      (readBack),
      .miso        (miso),
      .misoOe      (misoOe),
      .rxWord      (rxWord),
      .rxValid     (rxValid)
   );

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         readyCnt    <= 32'h00000000;
         readyForUse <= 1'b0;
      end
      else if (!readyForUse)
      begin
         if (readyCnt == READY_CYCLES - 1)
            readyForUse <= 1'b1;
         readyCnt <= readyCnt + 32'h00000001;
      end
   end

   assign cmdValid = rxValid && readyForUse;
   assign cmdWrite = cmdValid && rxWord.wr;
   assign wordAddr = {rxWord.addr[6:1], 1'b0};
   assign diagRead = cmdValid && !rxWord.wr && (wordAddr == `IMS_ADDR_DIAG);

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         rateClk   <= `IMS_RST_RATE_CLK;
         rangeFilt <= `IMS_RST_RANGE_FILT;
      end
      else if (cmdWrite)
      begin
         case (rxWord.addr)
            `IMS_ADDR_RATE_CLK:   rateClk.useInternal          <= rxWord.data[0];
            `IMS_ADDR_RATE_HI:    rateClk.outputRateSel        <= rxWord.data[3:0];
            `IMS_ADDR_RANGE_FILT: rangeFilt.smoothingFilterSel <= rxWord.data;
            `IMS_ADDR_RANGE_HI:   rangeFilt.rangeSel           <= rxWord.data[3:0];
            default:              rateClk                      <= rateClk;
         endcase
      end
   end

   assign useInternalClk     = rateClk.useInternal;
   assign outputRateSel      = rateClk.outputRateSel;
   assign rangeSel           = rangeFilt.rangeSel;
   assign smoothingFilterSel = rangeFilt.smoothingFilterSel;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         msCnt    <= 32'h00000000;
         syncSync <= 2'h0;
         syncPrev <= 1'b0;
      end
      else
      begin
         syncSync <= {syncSync[0], syncPin};
         syncPrev <= syncSync[1];
         if (msCnt == TICK_CYCLES - 1)
            msCnt <= 32'h00000000;
         else
            msCnt <= msCnt + 32'h00000001;
      end
   end

   assign msTick = rateClk.useInternal ? (msCnt == TICK_CYCLES - 1) : (syncSync[1] & ~syncPrev);

   // Rate code to period in ticks
   always_comb
   begin
      case (rateClk.outputRateSel)
         4'h1:    ratePeriod = `IMS_PER_200HZ;
         4'h2:    ratePeriod = `IMS_PER_100HZ;
         4'h3:    ratePeriod = `IMS_PER_50HZ;
         4'h4:    ratePeriod = `IMS_PER_25HZ;
         4'h5:    ratePeriod = `IMS_PER_20HZ;
         4'h6:    ratePeriod = `IMS_PER_10HZ;
         4'h7:    ratePeriod = `IMS_PER_5HZ;
         4'h8:    ratePeriod = `IMS_PER_4HZ;
         4'h9:    ratePeriod = `IMS_PER_2HZ;
         4'hA:    ratePeriod = `IMS_PER_1HZ;
         default: ratePeriod = 10'h000;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         rateCnt   <= 10'h000;
         dataReady <= 1'b0;
      end
      else if (msTick || ratePeriod == 10'h000)
      begin
         if (ratePeriod == 10'h000)
         begin
            rateCnt   <= 10'h000;
            dataReady <= 1'b0;
         end
         else if (rateCnt >= 10'(ratePeriod - 10'h001))
         begin
            rateCnt   <= 10'h000;
            dataReady <= 1'b1;
         end
         else
         begin
            rateCnt   <= 10'(rateCnt + 10'h001);
            dataReady <= 1'b0;
         end
      end
   end

   // Range to scale shift and limit
   always_comb
   begin
      case (rangeFilt.rangeSel)
         `IMS_RANGE_SMALL:
         begin
            rangeShift = 2'h0;
            rangeLimit = `IMS_LIM_SMALL;
         end
         `IMS_RANGE_LARGE:
         begin
            rangeShift = 2'h2;
            rangeLimit = `IMS_LIM_LARGE;
         end
         default:
         begin
            rangeShift = 2'h1;
            rangeLimit = `IMS_LIM_MID;
         end
      endcase
   end

   for (genvar ax = 0; ax < 3; ax++)
   begin : g_axis
      logic signed [19:0] raw;
      logic signed [19:0] shifted;
      logic [19:0]        mag;
      assign raw     = rateRaw[ax];
      assign mag     = raw[19] ? 20'(-raw) : raw;
      assign shifted = raw >>> rangeShift;
      assign exceed[ax] = mag > rangeLimit;
      always_ff @(posedge core_clk)
      begin
         if (!rst_n)
            scaledRate[ax] <= 16'h0000;
         else if (shifted > 20'sh07FFF)
            scaledRate[ax] <= 16'h7FFF;
         else if (shifted < 20'shF8000)
            scaledRate[ax] <= 16'h8000;
         else
            scaledRate[ax] <= shifted[15:0];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         overRange <= 1'b0;
      else if (|exceed)
         overRange <= 1'b1;
      else if (diagRead)
         overRange <= 1'b0;
   end

   assign alignGo = cmdWrite && (rxWord.addr == `IMS_ADDR_ALIGN) && (rxWord.data == `IMS_ALIGN_CMD)
                    && (alignState == AL_IDLE) && !stabilizeMode;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         alignState  <= AL_IDLE;
         alignStart  <= 1'b0;
         nvmStore    <= 1'b0;
         alignInit   <= `IMS_RST_ALIGN_INIT;
         alignStatus <= `IMS_ST_IDLE;
         alignStore  <= '0;
      end
      else
      begin
         alignStart <= 1'b0;
         nvmStore   <= 1'b0;
         case (alignState)
            AL_IDLE:
               if (alignGo)
               begin
                  alignState  <= AL_RUN;
                  alignStart  <= 1'b1;
                  alignInit   <= rxWord.data;
                  alignStatus <= `IMS_ST_BUSY;
               end
            AL_RUN:
               if (alignDone)
               begin
                  alignState  <= AL_IDLE;
                  alignStore  <= alignResult;
                  nvmStore    <= 1'b1;
                  alignInit   <= `IMS_RST_ALIGN_INIT;
                  alignStatus <= `IMS_ST_DONE;
               end
            default:
               alignState <= AL_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         stabCnt       <= 32'h00000000;
         stabilizeMode <= 1'b0;
      end
      else if (alignState == AL_RUN && alignDone)
      begin
         stabCnt       <= 32'h00000000;
         stabilizeMode <= 1'b1;
      end
      else if (stabilizeMode)
      begin
         if (stabCnt == STAB_CYCLES - 1)
            stabilizeMode <= 1'b0;
         stabCnt <= stabCnt + 32'h00000001;
      end
   end

   // Read mux of result and config registers
   always_comb
   begin
      readData = 16'h0000;
      case (wordAddr)
         `IMS_ADDR_DATA_X:     readData = scaledRate[0];
         `IMS_ADDR_DATA_Y:     readData = scaledRate[1];
         `IMS_ADDR_DATA_Z:     readData = scaledRate[2];
         `IMS_ADDR_RATE_CLK:   readData = rateClk;
         `IMS_ADDR_RANGE_FILT: readData = rangeFilt;
         `IMS_ADDR_DIAG:       readData[`IMS_DIAG_OVR_BIT] = overRange;
         `IMS_ADDR_HARD_X:     readData = alignStore.hardX;
         `IMS_ADDR_HARD_Y:     readData = alignStore.hardY;
         `IMS_ADDR_SOFT_RATIO: readData = alignStore.softRatio;
         `IMS_ADDR_SOFT_ANGLE: readData = alignStore.softAngle;
         `IMS_ADDR_ALIGN:      readData = {alignInit, alignStatus};
         default:              readData = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         readBack <= 16'h0000;
      else if (cmdValid)
         readBack <= rxWord.wr ? 16'h0000 : readData;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   AST_RESET_VALUES: assert property ($rose(rst_n) |-> rateClk == `IMS_RST_RATE_CLK
      && rangeFilt == `IMS_RST_RANGE_FILT) else $error("reset values wrong");
   AST_RATE_WRITE: assert property (cmdWrite && rxWord.addr == `IMS_ADDR_RATE_HI
      |=> outputRateSel == $past(rxWord.data[3:0])) else $error("rate code not written");
   AST_NO_OUTPUT: assert property (ratePeriod == 10'h000 ##1 ratePeriod == 10'h000
      |-> !dataReady) else $error("data ready while suppressed");
   AST_CLK_WRITE: assert property (cmdWrite && rxWord.addr == `IMS_ADDR_RATE_CLK
      |=> useInternalClk == $past(rxWord.data[0])) else $error("clock select not written");
   AST_RANGE_WRITE: assert property (cmdWrite && rxWord.addr == `IMS_ADDR_RANGE_HI
      |=> rangeSel == $past(rxWord.data[3:0])) else $error("range code not written");
   AST_OVER_RANGE: assert property (|exceed |=> overRange)
      else $error("over-range flag missed");
   AST_ALIGN_GO: assert property (alignGo |=> alignStart && alignStatus == `IMS_ST_BUSY)
      else $error("alignment did not start");
   AST_ALIGN_BUSY: assert property (alignState == AL_RUN |-> alignStatus == `IMS_ST_BUSY)
      else $error("status not busy while running");
   AST_ALIGN_DONE: assert property (alignState == AL_RUN && alignDone |=> nvmStore
      && alignStore == $past(alignResult) && alignStatus == `IMS_ST_DONE) else $error("results not stored");
   AST_STAB_ENTRY: assert property ($rose(stabilizeMode) |-> $past(alignDone)
      && alignStatus == `IMS_ST_DONE) else $error("stabilization without completion");
   AST_NOT_READY: assert property (rxValid && !readyForUse |=> $stable(rateClk)
      && $stable(rangeFilt)) else $error("command taken before ready");

   COV_RATE_CHANGE: cover property (cmdWrite && rxWord.addr == `IMS_ADDR_RATE_HI);
   COV_DATA_READY:  cover property ($rose(dataReady));
   COV_ALIGN_DONE:  cover property (alignGo ##[1:1000] nvmStore);
   COV_OVER_RANGE:  cover property ($rose(overRange));

endmodule : ims_config_regs

// *** core/ims_map.svh ***
// Register map, field positions, reset values and timing counts
`ifndef IMS_MAP_SVH
`define IMS_MAP_SVH

`define IMS_ADDR_DATA_X       7'h04
`define IMS_ADDR_DATA_Y       7'h06
`define IMS_ADDR_DATA_Z       7'h08
`define IMS_ADDR_RATE_CLK     7'h36
`define IMS_ADDR_RATE_HI      7'h37
`define IMS_ADDR_RANGE_FILT   7'h38
`define IMS_ADDR_RANGE_HI     7'h39
`define IMS_ADDR_DIAG         7'h3C
`define IMS_ADDR_HARD_X       7'h48
`define IMS_ADDR_HARD_Y       7'h4A
`define IMS_ADDR_SOFT_RATIO   7'h4C
`define IMS_ADDR_SOFT_ANGLE   7'h4E
`define IMS_ADDR_ALIGN        7'h50

`define IMS_RST_RATE_CLK      16'h0101
`define IMS_RST_RANGE_FILT    16'h0206
`define IMS_RST_ALIGN_INIT    8'h00
`define IMS_DIAG_OVR_BIT      4

`define IMS_ALIGN_CMD         8'h01
`define IMS_ST_IDLE           8'h00
`define IMS_ST_DONE           8'h0B
`define IMS_ST_BUSY           8'h0C

`define IMS_RANGE_SMALL       4'h1
`define IMS_RANGE_MID         4'h2
`define IMS_RANGE_LARGE       4'h4
`define IMS_LIM_SMALL         20'h061A8
`define IMS_LIM_MID           20'h0C350
`define IMS_LIM_LARGE         20'h186A0

`define IMS_PER_200HZ         10'h005
`define IMS_PER_100HZ         10'h00A
`define IMS_PER_50HZ          10'h014
`define IMS_PER_25HZ          10'h028
`define IMS_PER_20HZ          10'h032
`define IMS_PER_10HZ          10'h064
`define IMS_PER_5HZ           10'h0C8
`define IMS_PER_4HZ           10'h0FA
`define IMS_PER_2HZ           10'h1F4
`define IMS_PER_1HZ           10'h3E8

`define IMS_CLK_KHZ           125000
`define IMS_TICK_MS           1
`define IMS_TICK_CYCLES       (`IMS_TICK_MS * `IMS_CLK_KHZ)
`define IMS_READY_MS          100
`define IMS_READY_CYCLES      (`IMS_READY_MS * `IMS_CLK_KHZ)
`define IMS_STAB_S            5
`define IMS_STAB_CYCLES       (`IMS_STAB_S * 1000 * `IMS_CLK_KHZ)

`endif

// *** core/ims_pkg.sv ***
// Types shared by the configuration register bank
package ims_pkg;

   typedef struct packed {
      logic       wr;
      logic [6:0] addr;
      logic [7:0] data;
   } ims_spi_word_t;

   typedef struct packed {
      logic [3:0] spareHi;
      logic [3:0] outputRateSel;
      logic [6:0] spareLo;
      logic       useInternal;
   } ims_rate_clk_t;

   typedef struct packed {
      logic [3:0] spareHi;
      logic [3:0] rangeSel;
      logic [7:0] smoothingFilterSel;
   } ims_range_filt_t;

   typedef struct packed {
      logic [15:0] hardX;
      logic [15:0] hardY;
      logic [15:0] softRatio;
      logic [15:0] softAngle;
   } ims_align_res_t;

   typedef logic [2:0][19:0] ims_rate_raw_t;
   typedef logic [2:0][15:0] ims_rate_out_t;

   typedef enum logic [0:0] {AL_IDLE, AL_RUN} ims_align_state_t;

endpackage : ims_pkg

// *** core/ims_spi_shift.sv ***
// SPI slave word shifter, mode 3, sampled by the core clock
`timescale 1ns/1ps
module ims_spi_shift
   import ims_pkg::*;
(
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   input  wire logic          sclkPin,
   input  wire logic          mosiPin,
   input  wire logic          selectPin_n,
   input  wire logic [15:0]   txWord,
   output logic               miso,
   output logic               misoOe,
   output ims_spi_word_t      rxWord,
   output logic               rxValid
);
   logic [2:0]  sclkSync;
   logic [1:0]  mosiSync;
   logic [1:0]  selSync_n;
   logic [3:0]  bitCnt;
   logic [15:0] rxShift;
   logic [15:0] txShift;
   logic        sclkRise;
   logic        sclkFall;
   logic        active;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         sclkSync  <= 3'h7;
         mosiSync  <= 2'h0;
         selSync_n <= 2'h3;
      end
      else
      begin
         sclkSync  <= {sclkSync[1:0], sclkPin};
         mosiSync  <= {mosiSync[0], mosiPin};
         selSync_n <= {selSync_n[0], selectPin_n};
      end
   end

   assign sclkRise = sclkSync[1] & ~sclkSync[2];
   assign sclkFall = ~sclkSync[1] & sclkSync[2];
   assign active   = ~selSync_n[1];

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         bitCnt  <= 4'h0;
         rxShift <= 16'h0000;
         txShift <= 16'h0000;
         rxWord  <= 16'h0000;
         rxValid <= 1'b0;
         miso    <= 1'b1;
         misoOe  <= 1'b0;
      end
      else
      begin
         rxValid <= 1'b0;
         misoOe  <= active;
         if (!active)
         begin
            bitCnt <= 4'h0;
         end
         else
         begin
            if (sclkFall)
            begin
               if (bitCnt == 4'h0)
               begin
                  miso    <= txWord[15];
                  txShift <= {txWord[14:0], 1'b0};
               end
               else
               begin
                  miso    <= txShift[15];
                  txShift <= {txShift[14:0], 1'b0};
               end
            end
            if (sclkRise)
            begin
               rxShift <= {rxShift[14:0], mosiSync[1]};
               bitCnt  <= 4'(bitCnt + 4'h1);
               if (bitCnt == 4'hF)
               begin
                  rxWord  <= {rxShift[14:0], mosiSync[1]};
                  rxValid <= 1'b1;
               end
            end
         end
      end
   end

endmodule : ims_spi_shift

// *** tb/ims_spi_host.sv ***
// SPI master model for the register bank link
`timescale 1ns/1ps
module ims_spi_host
(
   input  wire logic core_clk,
   input  wire logic miso,
   output logic      sclkPin,
   output logic      mosiPin,
   output logic      selectPin_n
);
   initial
   begin
      sclkPin = 1'b1;
      mosiPin = 1'b0;
      selectPin_n = 1'b1;
   end

   task automatic hold(input int cnt);
      repeat (cnt) @(negedge core_clk);
   endtask : hold

   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      selectPin_n = 1'b0;
      hold(4);
      for (int i = 15; i >= 0; i--)
      begin
         sclkPin = 1'b0;
         mosiPin = w[i];
         hold(4);
         r[i] = miso;
         sclkPin = 1'b1;
         hold(4);
      end
      hold(8);
      selectPin_n = 1'b1;
      mosiPin = ~mosiPin;
      hold(16);
   endtask : xfer
endmodule : ims_spi_host

// *** tb/ims_config_regs_tb.sv ***
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module ims_config_regs_tb
   import ims_pkg::*;
;
   logic           core_clk;
   logic           rst_n;
   logic           sclkPin;
   logic           mosiPin;
   logic           selectPin_n;
   logic           syncPin;
   logic           alignDone;
   logic           miso;
   logic           misoOe;
   logic           dataReady;
   logic           readyForUse;
   logic           alignStart;
   logic           nvmStore;
   logic           stabilizeMode;
   logic           useInternalClk;
   logic [3:0]     outputRateSel;
   logic [3:0]     rangeSel;
   logic [7:0]     smoothingFilterSel;
   ims_rate_raw_t  rateRaw;
   ims_align_res_t alignResult;
   ims_align_res_t alignStore;
   ims_rate_out_t  scaledRate;
   int             error_cnt;
   int             comparisons;
   int             seed;
   int             startCnt;
   int             nvmCnt;
   int             n;
   logic [15:0]    v;
   logic [7:0]     filt [9] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h30, 8'h40, 8'h50, 8'h60};
   logic [3:0]     rng [3]  = '{4'h1, 4'h2, 4'h4};
   int             rc [3]   = '{1, 2, 10};
   int             rp [3]   = '{100, 200, 20000};

   ims_config_regs #(.TICK_CYCLES(20), .READY_CYCLES(50), .STAB_CYCLES(100)) u_dut
   (
      .*
   );

   ims_spi_host u_host
   (
      .*
   );

   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   initial
   begin
      syncPin = 1'b0;
      forever
      begin
         repeat (15) @(negedge core_clk);
         syncPin = ~syncPin;
      end
   end

   always @(posedge core_clk)
   begin
      if (alignStart === 1'b1)
         startCnt <= startCnt + 1;
      if (nvmStore === 1'b1)
         nvmCnt <= nvmCnt + 1;
   end

   task automatic end_sim;
      $display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      u_host.xfer({1'b1, a, d}, v);
   endtask : wr

   task automatic rd(input logic [6:0] a);
      u_host.xfer({1'b0, a, 8'h00}, v);
      u_host.xfer(16'h0000, v);
   endtask : rd

   task automatic edgeWait;
      logic p;
      n = 0;
      p = dataReady;
      while (!(dataReady === 1'b1 && p === 1'b0) && n < 30000)
      begin
         p = dataReady;
         @(negedge core_clk);
         n++;
      end
      if (n >= 30000)
      begin
         chk(n, 0);
         end_sim;
      end
   endtask : edgeWait

   function automatic logic [15:0] scl(input logic [19:0] raw, input logic [3:0] rg);
      return (rg == 4'h1) ? raw[15:0] : (rg == 4'h4) ? raw[17:2] : raw[16:1];
   endfunction : scl

   initial
   begin
      seed = 11756;
      rst_n = 1'b0;
      alignDone = 1'b0;
      alignResult = '0;
      rateRaw = '0;
      // Reset held for two clock cycles
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      chk({useInternalClk, outputRateSel, rangeSel, smoothingFilterSel}, 17'h11206);
      chk(misoOe, 1'b0);
      repeat (40) @(negedge core_clk);
      chk(readyForUse, 1'b0);
      n = 0;
      while (readyForUse !== 1'b1 && n < 20)
      begin
         @(negedge core_clk);
         n++;
      end
      chk(readyForUse, 1'b1);
      if (n >= 20)
         end_sim;
      fork
         rd(7'h36);
         begin
            repeat (20) @(negedge core_clk);
            chk(misoOe, 1'b1);
         end
      join
      chk(misoOe, 1'b0);
      chk(v, 16'h0101);
      rd(7'h38);
      chk(v, 16'h0206);
      foreach (filt[i])
      begin
         wr(7'h38, filt[i]);
         chk(smoothingFilterSel, filt[i]);
      end
      rd(7'h38);
      chk(v, 16'h0260);
      foreach (rng[i])
      begin
         for (int k = 0; k < 3; k++)
            rateRaw[k] = 20'($random(seed)) & 20'h07FFC;
         wr(7'h39, {4'h0, rng[i]});
         chk(rangeSel, rng[i]);
         for (int k = 0; k < 3; k++)
            chk(scaledRate[k], scl(rateRaw[k], rng[i]));
         edgeWait;
         rd(7'h04);
         chk(v, scl(rateRaw[0], rng[i]));
      end
      rateRaw[0] = 20'h186A0;
      rd(7'h3C);
      rd(7'h3C);
      chk(v, 16'h0000);
      rateRaw[0] = 20'h186A1;
      rd(7'h3C);
      chk(v, 16'h0010);
      rateRaw[0] = 20'h00000;
      foreach (rc[i])
      begin
         wr(7'h37, 8'(rc[i]));
         rd(7'h36);
         chk(v, {4'h0, 4'(rc[i]), 8'h01});
         edgeWait;
         edgeWait;
         chk(n, rp[i]);
      end
      wr(7'h37, 8'h00);
      n = 0;
      repeat (300)
      begin
         @(negedge core_clk);
         if (dataReady !== 1'b0)
            n++;
      end
      chk(n, 0);
      wr(7'h36, 8'h00);
      chk(useInternalClk, 1'b0);
      wr(7'h37, 8'h01);
      edgeWait;
      edgeWait;
      chk(n, 150);
      wr(7'h50, 8'h01);
      chk(startCnt, 1);
      rd(7'h50);
      chk(v, 16'h010C);
      alignResult = {$random(seed), $random(seed)};
      alignDone = 1'b1;
      @(negedge core_clk);
      alignDone = 1'b0;
      repeat (2) @(negedge core_clk);
      chk(nvmCnt, 1);
      chk(alignStore, alignResult);
      chk(stabilizeMode, 1'b1);
      repeat (97) @(negedge core_clk);
      chk(stabilizeMode, 1'b1);
      @(negedge core_clk);
      chk(stabilizeMode, 1'b0);
      rd(7'h50);
      chk(v, 16'h000B);
      rd(7'h4E);
      chk(v, alignResult.softAngle);
      chk(stabilizeMode, 1'b0);
      end_sim;
   end
endmodule : ims_config_regs_tb
